/* File: design/tct_cfg.svh */
`ifndef TCT_CFG_SVH
`define TCT_CFG_SVH

// register indices on the parameter load port
`define TCT_IDX_CRC_CFG   4'h4
`define TCT_IDX_CRC_POLY  4'h5
`define TCT_IDX_TAIL_SYS  4'h6
`define TCT_IDX_TAIL_PAR1 4'h7
`define TCT_IDX_TAIL_PAR2 4'h8

// field layout
`define TCT_PASS_MSB      12
`define TCT_PASS_LSB      8
`define TCT_LEN_MSB       5
`define TCT_LEN_LSB       0
`define TCT_TAIL_MSB      17
`define TCT_CRC_CFG_MASK  32'h0000_1F3F
`define TCT_TAIL_MASK     32'h0003_FFFF

// reset values
`define TCT_RST_WORD      32'h0000_0000
`define TCT_RST_PASS      5'h00
`define TCT_RST_LEN       6'h00
`define TCT_RST_TAIL      18'h0_0000
`define TCT_RST_CNT       5'h00

// constants
`define TCT_PASS_ZERO     5'h00
`define TCT_PASS_ONE      5'h01
`define TCT_PASS_MAX      5'h1F
`define TCT_LEN_OFF       6'h00
`define TCT_SYM_ZERO      6'h00

`endif

/* File: design/tct_pkg.sv */
package tct_pkg;

   // termination tracker state
   typedef enum logic {
      TCT_RUN,
      TCT_STOP
   } tct_state_t;

   // three 6-bit symbols, slot 0 in the low bits
   typedef logic [2:0][5:0] tct_tail_t;

endpackage : tct_pkg

/* File: design/tct_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tct_cfg.svh"

module tct_regs
   import tct_pkg::*;
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        arst_n_i,
   // parameter load port
   input  wire logic        reg_wr_en_i,
   input  wire logic        reg_rd_en_i,
   input  wire logic [3:0]  reg_addr_i,
   input  wire logic [31:0] reg_wdata_i,
   output logic      [31:0] reg_rdata_o,
   output logic             reg_rd_valid_o,
   // decoder mode and iteration results
   input  wire logic        shared_mode_i,
   input  wire logic        decode_start_i,
   input  wire logic        iter_done_i,
   input  wire logic        iter_crc_pass_i,
   // configuration toward the decoder
   output logic             crc_enable_o,
   output logic      [5:0]  crc_length_o,
   output logic      [31:0] crc_poly_value_o,
   output logic             crc_terminate_o,
   output logic      [4:0]  crc_pass_run_o,
   output tct_tail_t        tail_sys_o,
   output tct_tail_t        tail_par1_o,
   output tct_tail_t        tail_par2_o,
   output logic             tail_ext_enable_o
);

   ////////////////////////////////////////////////////////////////////////////
   // register storage

   logic [4:0]  crc_pass_count;
   logic [5:0]  crc_length;
   logic [31:0] crc_poly;
   logic [17:0] tail_field_one;
   logic [17:0] tail_field_two;
   logic [17:0] tail_field_three;
   logic [31:0] next_rdata;
   logic [4:0]  pass_target;
   logic [4:0]  pass_run;
   logic [4:0]  next_run;
   tct_state_t  state;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         crc_pass_count <= `TCT_RST_PASS;
         crc_length     <= `TCT_RST_LEN;
      end else if (reg_wr_en_i && reg_addr_i == `TCT_IDX_CRC_CFG) begin
         crc_pass_count <= reg_wdata_i[`TCT_PASS_MSB:`TCT_PASS_LSB];
         crc_length     <= reg_wdata_i[`TCT_LEN_MSB:`TCT_LEN_LSB];
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         crc_poly <= `TCT_RST_WORD;
      end else if (reg_wr_en_i && reg_addr_i == `TCT_IDX_CRC_POLY) begin
         crc_poly <= reg_wdata_i;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tail_field_one   <= `TCT_RST_TAIL;
         tail_field_two   <= `TCT_RST_TAIL;
         tail_field_three <= `TCT_RST_TAIL;
      end else if (reg_wr_en_i) begin
         unique case (reg_addr_i)
            `TCT_IDX_TAIL_SYS:  tail_field_one   <= reg_wdata_i[`TCT_TAIL_MSB:0];
            `TCT_IDX_TAIL_PAR1: tail_field_two   <= reg_wdata_i[`TCT_TAIL_MSB:0];
            `TCT_IDX_TAIL_PAR2: tail_field_three <= reg_wdata_i[`TCT_TAIL_MSB:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read path, one cycle latency, unmapped reads zero

   always_comb begin
      unique case (reg_addr_i)
         `TCT_IDX_CRC_CFG: begin
            next_rdata = `TCT_RST_WORD;
            next_rdata[`TCT_PASS_MSB:`TCT_PASS_LSB] = crc_pass_count;
            next_rdata[`TCT_LEN_MSB:`TCT_LEN_LSB]   = crc_length;
         end
         `TCT_IDX_CRC_POLY:  next_rdata = crc_poly;
         `TCT_IDX_TAIL_SYS:  next_rdata = {14'h0000, tail_field_one};
         `TCT_IDX_TAIL_PAR1: next_rdata = {14'h0000, tail_field_two};
         `TCT_IDX_TAIL_PAR2: next_rdata = {14'h0000, tail_field_three};
         default:            next_rdata = `TCT_RST_WORD;
      endcase
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         reg_rdata_o    <= `TCT_RST_WORD;
         reg_rd_valid_o <= 1'b0;
      end else begin
         reg_rdata_o    <= reg_rd_en_i ? next_rdata : `TCT_RST_WORD;
         reg_rd_valid_o <= reg_rd_en_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // crc early termination tracker

   assign pass_target = (crc_pass_count == `TCT_PASS_ZERO) ? `TCT_PASS_ONE
                                                           : crc_pass_count;
   assign next_run    = (pass_run == `TCT_PASS_MAX) ? pass_run : pass_run + `TCT_PASS_ONE;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pass_run <= `TCT_RST_CNT;
         state    <= TCT_RUN;
      end else if (decode_start_i) begin
         pass_run <= `TCT_RST_CNT;
         state    <= TCT_RUN;
      end else if (iter_done_i && crc_enable_o && state == TCT_RUN) begin
         if (!iter_crc_pass_i) begin
            pass_run <= `TCT_RST_CNT;
         end else begin
            pass_run <= next_run;
            if (next_run >= pass_target) begin
               state <= TCT_STOP;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs toward the decoder

   assign crc_enable_o      = (crc_length != `TCT_LEN_OFF);
   assign crc_length_o      = crc_length;
   assign crc_poly_value_o  = crc_poly;
   assign crc_terminate_o   = (state == TCT_STOP);
   assign crc_pass_run_o    = pass_run;
   assign tail_sys_o        = tail_field_one;
   assign tail_par1_o       = tail_field_two;
   assign tail_par2_o       = tail_field_three;
   assign tail_ext_enable_o = !shared_mode_i;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   pass_zero_one_a: assert property (
      (state == TCT_RUN && !decode_start_i && iter_done_i && iter_crc_pass_i
       && crc_enable_o && crc_pass_count == `TCT_PASS_ZERO)
      |=> crc_terminate_o)
      else $error("zero pass count did not stop after one pass");

   pass_early_stop_a: assert property (
      $rose(crc_terminate_o) |-> pass_run >= pass_target)
      else $error("termination before enough passing iterations");

   crc_off_idle_a: assert property (
      (!crc_enable_o && !crc_terminate_o && !decode_start_i) |=> !crc_terminate_o)
      else $error("termination while crc disabled");

   poly_write_a: assert property (
      (reg_wr_en_i && reg_addr_i == `TCT_IDX_CRC_POLY)
      |=> crc_poly_value_o == $past(reg_wdata_i))
      else $error("polynomial write not stored");

   reserved_zero_a: assert property (
      reg_rd_valid_o && $past(reg_addr_i) == `TCT_IDX_CRC_CFG
      |-> (reg_rdata_o & ~`TCT_CRC_CFG_MASK) == `TCT_RST_WORD)
      else $error("reserved config bits read nonzero");

   tail_reserved_a: assert property (
      reg_rd_valid_o && $past(reg_addr_i) inside {`TCT_IDX_TAIL_SYS, `TCT_IDX_TAIL_PAR1,
                                                  `TCT_IDX_TAIL_PAR2}
      |-> (reg_rdata_o & ~`TCT_TAIL_MASK) == `TCT_RST_WORD)
      else $error("reserved tail bits read nonzero");

   shared_ext_off_a: assert property (
      shared_mode_i |-> !tail_ext_enable_o)
      else $error("extra tail registers used in shared mode");

   tail_slot_a: assert property (
      (reg_wr_en_i && reg_addr_i == `TCT_IDX_TAIL_PAR1)
      |=> tail_par1_o[2] == $past(reg_wdata_i[17:12])
          && tail_par1_o[0] == $past(reg_wdata_i[5:0]))
      else $error("tail slot placement wrong");

   fail_clears_a: assert property (
      (state == TCT_RUN && !decode_start_i && iter_done_i && !iter_crc_pass_i
       && crc_enable_o) |=> pass_run == `TCT_RST_CNT && !crc_terminate_o)
      else $error("failed iteration did not clear pass run");

endmodule : tct_regs

`default_nettype wire

/* File: verif/tct_dma_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tct_cfg.svh"

module tct_dma_model (
   // clock
   input  wire logic        clk_i,
   // load port
   output logic             wr_en_o,
   output logic             rd_en_o,
   output logic      [3:0]  addr_o,
   output logic      [31:0] wdata_o,
   input  wire logic [31:0] rdata_i
);
   initial begin
      wr_en_o = 1'b0;
      rd_en_o = 1'b0;
      addr_o  = 4'h0;
      wdata_o = 32'h0;
   end

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(negedge clk_i);
      wr_en_o = 1'b1;
      addr_o  = a;
      wdata_o = d;
      @(negedge clk_i);
      wr_en_o = 1'b0;
      // a released data bus shows no stale word
      wdata_o = ~d;
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(negedge clk_i);
      rd_en_o = 1'b1;
      addr_o  = a;
      @(negedge clk_i);
      rd_en_o = 1'b0;
      d       = rdata_i;
   endtask : rd

   // every tail word goes in before a decode is started
   task automatic load_tails(input logic [31:0] s, input logic [31:0] p1, input logic [31:0] p2);
      wr(`TCT_IDX_TAIL_SYS, s);
      wr(`TCT_IDX_TAIL_PAR1, p1);
      wr(`TCT_IDX_TAIL_PAR2, p2);
   endtask : load_tails
endmodule : tct_dma_model
`default_nettype wire

/* File: verif/tb_turbo_crc_tail_config.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_turbo_crc_tail_config;
   import tct_pkg::*;
   logic        clk = 1'b0;
   logic        arst_n = 1'b0;
   logic        wr_en, rd_en, rd_valid, shared = 1'b0, start = 1'b0;
   logic        done = 1'b0, pass = 1'b0, crc_en, term, ext;
   logic [3:0]  addr;
   logic [31:0] wdata, rdata, poly, d;
   logic [5:0]  len;
   logic [4:0]  run;
   tct_tail_t   tsys, tp1, tp2;
   int          n_fail = 0;
   int          cmp_count = 0;

   always #5 clk = ~clk;

   tct_dma_model tct_dma_model_inst (.clk_i(clk), .wr_en_o(wr_en), .rd_en_o(rd_en),
      .addr_o(addr), .wdata_o(wdata), .rdata_i(rdata));
   tct_regs tct_regs_inst (.clk_i(clk), .arst_n_i(arst_n), .reg_wr_en_i(wr_en),
      .reg_rd_en_i(rd_en), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
      .reg_rd_valid_o(rd_valid), .shared_mode_i(shared), .decode_start_i(start),
      .iter_done_i(done), .iter_crc_pass_i(pass), .crc_enable_o(crc_en),
      .crc_length_o(len), .crc_poly_value_o(poly), .crc_terminate_o(term),
      .crc_pass_run_o(run), .tail_sys_o(tsys), .tail_par1_o(tp1), .tail_par2_o(tp2),
      .tail_ext_enable_o(ext));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic iter(input logic p);
      @(negedge clk);
      done = 1'b1;
      pass = p;
      @(negedge clk);
      done = 1'b0;
   endtask : iter

   task automatic new_decode(input logic [31:0] cfg);
      tct_dma_model_inst.wr(4'h4, cfg);
      @(negedge clk);
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
   endtask : new_decode

   task automatic t_reset();
      for (int i = 4; i <= 9; i++) begin
         tct_dma_model_inst.rd(4'(i), d);
         chk(d, 32'h0);
         chk(32'(rd_valid), 32'h1);
      end
      chk(32'(crc_en), 32'h0);
      chk(32'(ext), 32'h1);
   endtask : t_reset

   task automatic t_fields();
      tct_dma_model_inst.wr(4'h4, 32'hFFFF_FFFF);
      tct_dma_model_inst.rd(4'h4, d);
      chk(d, 32'h0000_1F3F);
      tct_dma_model_inst.wr(4'h5, 32'h8000_0043);
      tct_dma_model_inst.rd(4'h5, d);
      chk(d, 32'h8000_0043);
      chk(poly, 32'h8000_0043);
      tct_dma_model_inst.load_tails(32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
      tct_dma_model_inst.rd(4'h8, d);
      chk(d, 32'h0003_FFFF);
      // rate 3/4 pattern: systematic value 0x15 in every slot, parity in slot zero only
      tct_dma_model_inst.load_tails(32'h0001_5555, 32'h0000_002A, 32'h0);
      chk(32'(tsys[2]), 32'h15);
      chk(32'(tp1), 32'h2A);
      chk(32'(tp2), 32'h0);
   endtask : t_fields

   task automatic t_pass_zero();
      new_decode(32'h0000_0006);
      chk(32'(len), 32'h6);
      chk(32'(crc_en), 32'h1);
      iter(1'b1);
      chk(32'(term), 32'h1);
      iter(1'b1);
      chk(32'(run), 32'h1);
   endtask : t_pass_zero

   task automatic t_fail_clears();
      new_decode(32'h0000_0306);
      chk(32'(term), 32'h0);
      iter(1'b1);
      iter(1'b1);
      iter(1'b0);
      chk(32'(run), 32'h0);
      iter(1'b1);
      iter(1'b1);
      chk(32'(term), 32'h0);
      iter(1'b1);
      chk(32'({run, 3'h0, term}), 32'h31);
   endtask : t_fail_clears

   task automatic t_len_zero_shared();
      new_decode(32'h0000_0100);
      chk(32'(crc_en), 32'h0);
      iter(1'b1);
      chk(32'({run, 3'h0, term}), 32'h0);
      @(negedge clk);
      shared = 1'b1;
      #1;
      chk(32'(ext), 32'h0);
   endtask : t_len_zero_shared

   task automatic tally_and_finish();
      if (n_fail == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      repeat (12) @(posedge clk);
      @(negedge clk);
      arst_n = 1'b1;
      t_reset();
      t_fields();
      t_pass_zero();
      t_fail_clears();
      t_len_zero_shared();
      tally_and_finish();
   end

   initial begin
      #20us;
      n_fail++;
      tally_and_finish();
   end
endmodule : tb_turbo_crc_tail_config
`default_nettype wire
